/* File: hw/adcsel_pkg.sv */
package adcsel_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  // Byte address of the aux select register
  localparam logic [7:0] SEL_ADDR = 8'h00;
  // Byte address of the amp/mode control register
  localparam logic [7:0] CTRL_ADDR = 8'h04;
  // Byte address of the routed-source status register
  localparam logic [7:0] ROUTE_ADDR = 8'h08;
  // Register width
  localparam int REG_W = 16;
  // Field positions in the select register
  localparam int POS_SA = 0;
  localparam int POS_NA_LO = 1;
  localparam int POS_NA_HI = 2;
  localparam int POS_SB = 8;
  localparam int POS_NB_LO = 9;
  localparam int POS_NB_HI = 10;
  // Implemented-bit mask of the select register
  localparam logic [15:0] SEL_MASK = 16'h0707;
  // Reset value of the select and control registers
  localparam logic [15:0] SEL_RESET = 16'h0000;
  // Control register fields
  localparam int POS_TWELVE = 0;
  localparam int POS_AMP1 = 1;
  localparam int POS_AMP2 = 2;
  localparam int POS_AMP3 = 3;
  localparam int POS_CMPEN = 4;
  localparam logic [15:0] CTRL_MASK = 16'h001f;
  // Negative field codes
  localparam logic [1:0] NEG_HIGH_INPUTS = 2'h3;
  localparam logic [1:0] NEG_MID_INPUTS = 2'h2;
  // ==========================================================
  // Source encoding of one sample input
  // ==========================================================
  typedef enum logic [4:0] {
    SRC_AN0, SRC_AN1, SRC_AN2, SRC_AN3, SRC_AN6, SRC_AN7, SRC_AN8, SRC_AN9,
    SRC_ANALOG_INPUT_10, SRC_ANALOG_INPUT_11, SRC_AMP1, SRC_AMP2, SRC_AMP3, SRC_VREFL, SRC_VSS
  } adcsel_src_t;
endpackage : adcsel_pkg

/* File: hw/adcsel_route.sv */
`timescale 1ns/1ns
// ==========================================================
// One set of channel 1..3 routing decode
// ==========================================================
module adcsel_route
  import adcsel_pkg::*;
(
  input wire logic posSel,
  input wire logic [1:0] negSel,
  input wire logic [2:0] ampOn,
  input wire logic cmpOn,
  output adcsel_pkg::adcsel_src_t posSrc [3],
  output adcsel_pkg::adcsel_src_t negSrc [3]
);
  // Pick amp output when its mode bit is set, else the pin
  function automatic adcsel_src_t ampOrPin(input logic on, input adcsel_src_t amp, input adcsel_src_t pin);
    return on ? amp : pin;
  endfunction : ampOrPin

  // Pins 0..7 are lent to comparators; then they read as ground
  function automatic adcsel_src_t lend(input adcsel_src_t s, input logic c);
    logic low;
    low = (s == SRC_AN0) || (s == SRC_AN1) || (s == SRC_AN2) || (s == SRC_AN3) ||
          (s == SRC_AN6) || (s == SRC_AN7);
    return (c && low) ? SRC_VSS : s;
  endfunction : lend

  // Routing table
  always_comb begin
    if (posSel) begin
      posSrc[0] = lend(ampOrPin(ampOn[0], SRC_AMP1, SRC_AN3), cmpOn);
      posSrc[1] = lend(ampOrPin(ampOn[1], SRC_AMP2, SRC_AN0), cmpOn);
      posSrc[2] = lend(ampOrPin(ampOn[2], SRC_AMP3, SRC_AN6), cmpOn);
    end else begin
      posSrc[0] = lend(ampOrPin(ampOn[1], SRC_AMP2, SRC_AN0), cmpOn);
      posSrc[1] = lend(SRC_AN1, cmpOn);
      posSrc[2] = lend(SRC_AN2, cmpOn);
    end
    case (negSel)
      NEG_HIGH_INPUTS: begin
        negSrc[0] = SRC_AN9;
        negSrc[1] = SRC_ANALOG_INPUT_10;
        negSrc[2] = SRC_ANALOG_INPUT_11;
      end
      NEG_MID_INPUTS: begin
        negSrc[0] = lend(ampOrPin(ampOn[2], SRC_AMP3, SRC_AN6), cmpOn);
        negSrc[1] = lend(SRC_AN7, cmpOn);
        negSrc[2] = SRC_AN8;
      end
      default: begin
        negSrc[0] = SRC_VREFL;
        negSrc[1] = SRC_VREFL;
        negSrc[2] = SRC_VREFL;
      end
    endcase
  end
endmodule : adcsel_route

/* File: hw/adcsel_top.sv */
`timescale 1ns/1ns
// Overview of operation
// - Bits fifteen to eleven read zero, ignore writes
// - Set B negative code picks high, mid, reference
// - Set B negative field reads zero in 12-bit
// - Set B positive bit eight routes amp/pins
// - Set B positive bit reads zero in 12-bit
// - Bits seven to three read zero, ignore writes
// - Set A negative field same coding as B
// - Set A negative field reads zero in 12-bit
// - Amp output used only when mode bit set
// - Low pins lost when comparator function enabled
module adcsel_top
  import adcsel_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output adcsel_pkg::adcsel_src_t muxAPos [3],
  output adcsel_pkg::adcsel_src_t muxANeg [3],
  output adcsel_pkg::adcsel_src_t muxBPos [3],
  output adcsel_pkg::adcsel_src_t muxBNeg [3]
);
  import adcsel_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [15:0] selStore;   // Raw stored select bits
    logic [15:0] ctrlStore;  // Mode and amp enables
    logic ack;               // Bus answer
    logic err;               // Unmapped answer
    logic [31:0] rdData;     // Read data
  } adcsel_state_t;

  adcsel_state_t state_reg; // Registered state
  adcsel_state_t state_next; // Next state

  logic twelveBit; // 12-bit conversion selected
  logic [15:0] selView; // Select register as software sees it
  logic [15:0] routeView; // Route status view
  logic busReq; // New request this cycle
  logic hitSel; // Select register addressed
  logic hitCtrl; // Control register addressed
  logic hitRoute; // Route register addressed
  logic [15:0] laneMask; // Byte enables as a bit mask
  adcsel_src_t aPos [3]; // Set A decode
  adcsel_src_t aNeg [3];
  adcsel_src_t bPos [3]; // Set B decode
  adcsel_src_t bNeg [3];

  assign twelveBit = state_reg.ctrlStore[POS_TWELVE];

  // ==========================================================
  // Read view of the select register
  // ==========================================================
  // Storage is kept in 12-bit mode so the value returns when leaving it;
  // only the read view and the routing see the fields as absent.
  always_comb begin
    selView = state_reg.selStore & SEL_MASK;
    if (twelveBit) begin
      selView[POS_NB_HI:POS_NB_LO] = 2'h0;
      selView[POS_SB] = 1'b0;
      selView[POS_NA_HI:POS_NA_LO] = 2'h0;
    end
  end

  // ==========================================================
  // Routing of both sets
  // ==========================================================
  // Set A decode
  adcsel_route routeA (
    .posSel(selView[POS_SA]),
    .negSel(selView[POS_NA_HI:POS_NA_LO]),
    .ampOn({state_reg.ctrlStore[POS_AMP3], state_reg.ctrlStore[POS_AMP2], state_reg.ctrlStore[POS_AMP1]}),
    .cmpOn(state_reg.ctrlStore[POS_CMPEN]),
    .posSrc(aPos),
    .negSrc(aNeg)
  );

  // Set B decode
  adcsel_route routeB (
    .posSel(selView[POS_SB]),
    .negSel(selView[POS_NB_HI:POS_NB_LO]),
    .ampOn({state_reg.ctrlStore[POS_AMP3], state_reg.ctrlStore[POS_AMP2], state_reg.ctrlStore[POS_AMP1]}),
    .cmpOn(state_reg.ctrlStore[POS_CMPEN]),
    .posSrc(bPos),
    .negSrc(bNeg)
  );

  // Routing outputs follow the select read view and the control store directly
  assign muxAPos = aPos;
  assign muxANeg = aNeg;
  assign muxBPos = bPos;
  assign muxBNeg = bNeg;

  // Route status: channel 1 sources of set B
  assign routeView = {3'h0, bNeg[0], 3'h0, bPos[0]};

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  assign busReq = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
  assign hitSel = (wb_adr_i == SEL_ADDR);
  assign hitCtrl = (wb_adr_i == CTRL_ADDR);
  assign hitRoute = (wb_adr_i == ROUTE_ADDR);
  assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.err = 1'b0;
    if (busReq) begin
      if (hitSel || hitCtrl || hitRoute) begin
        state_next.ack = 1'b1;
      end else begin
        // Unmapped address answers with err
        state_next.err = 1'b1;
      end
      if (wb_we_i) begin
        // Masked bits never store, so reserved stay zero
        if (hitSel) begin
          state_next.selStore = ((state_reg.selStore & ~laneMask) | (wb_dat_i[15:0] & laneMask)) & SEL_MASK;
        end
        if (hitCtrl) begin
          state_next.ctrlStore = ((state_reg.ctrlStore & ~laneMask) | (wb_dat_i[15:0] & laneMask)) & CTRL_MASK;
        end
        state_next.rdData = 32'h0;
      end else begin
        if (hitSel) begin
          state_next.rdData = {16'h0, selView};
        end else if (hitCtrl) begin
          state_next.rdData = {16'h0, state_reg.ctrlStore};
        end else if (hitRoute) begin
          state_next.rdData = {16'h0, routeView};
        end else begin
          state_next.rdData = 32'h0;
        end
      end
    end
  end

  // State register; reset clears all implemented fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg.selStore <= SEL_RESET;
      state_reg.ctrlStore <= SEL_RESET;
      state_reg.ack <= 1'b0;
      state_reg.err <= 1'b0;
      state_reg.rdData <= 32'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_err_o = state_reg.err;
  assign wb_dat_o = state_reg.rdData;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Request sequences
  // ==========================================================
  // Read of the select register taken this cycle
  sequence selRead;
    busReq && !wb_we_i && hitSel;
  endsequence

  // Write of the select register taken this cycle
  sequence selWrite;
    busReq && wb_we_i && hitSel;
  endsequence

  // Read of the control register taken this cycle
  sequence ctrlRead;
    busReq && !wb_we_i && hitCtrl;
  endsequence

  // Write of the control register taken this cycle
  sequence ctrlWrite;
    busReq && wb_we_i && hitCtrl;
  endsequence

  // Read of the route status taken this cycle
  sequence routeRead;
    busReq && !wb_we_i && hitRoute;
  endsequence

  // Request to an address with no register behind it
  sequence badReq;
    busReq && !hitSel && !hitCtrl && !hitRoute;
  endsequence

  // One-cycle answer pulse; a longer one would retake the request
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  upper_zero_a: assert property (selRead |=> wb_dat_o[15:11] == 5'h0)
    else $error("upper select bits not zero");
  mid_zero_a: assert property (selRead |=> wb_dat_o[7:3] == 5'h0)
    else $error("middle select bits not zero");
  negb_twelve_a: assert property ((selRead and twelveBit) |=> wb_dat_o[10:9] == 2'h0)
    else $error("set B negative visible in 12-bit");
  posb_twelve_a: assert property ((selRead and twelveBit) |=> wb_dat_o[8] == 1'b0)
    else $error("set B positive visible in 12-bit");
  nega_twelve_a: assert property ((selRead and twelveBit) |=> wb_dat_o[2:1] == 2'h0)
    else $error("set A negative visible in 12-bit");
  negb_high_a: assert property (selView[10:9] == NEG_HIGH_INPUTS |-> muxBNeg[2] == SRC_ANALOG_INPUT_11)
    else $error("set B negative high code misrouted");
  nega_ref_a: assert property (!selView[2] |-> muxANeg[0] == SRC_VREFL)
    else $error("set A negative reference misrouted");
  posb_amp_a: assert property (selView[8] && state_reg.ctrlStore[POS_AMP1] |-> muxBPos[0] == SRC_AMP1)
    else $error("set B positive amp misrouted");
  posa_pin_a: assert property (!selView[0] && !state_reg.ctrlStore[POS_CMPEN] |-> muxAPos[1] == SRC_AN1)
    else $error("set A positive pin misrouted");
  cmp_lend_a: assert property (state_reg.ctrlStore[POS_CMPEN] && !selView[0] |-> muxAPos[2] == SRC_VSS)
    else $error("lent pin still routed");
  write_ack_a: assert property (busReq && wb_we_i && hitSel |=> wb_ack_o ##1 !wb_ack_o)
    else $error("select write not answered once");

  // ==========================================================
  // Read data and store checks
  // ==========================================================
  // Outside 12-bit mode a read returns the stored implemented bits
  sel_read_data_a: assert property (
    (selRead and !twelveBit) |=> wb_dat_o[15:0] == ($past(state_reg.selStore) & SEL_MASK))
    else $error("select read data differs from store");
  // In 12-bit mode the set A positive bit alone stays visible
  sel_read_sa_a: assert property (
    (selRead and twelveBit) |=> wb_dat_o[POS_SA] == $past(state_reg.selStore[POS_SA]))
    else $error("set A positive bit lost in 12-bit");
  // Upper half of the data bus carries no register bits
  rd_high_zero_a: assert property ((selRead or ctrlRead or routeRead) |=> wb_dat_o[31:16] == 16'h0)
    else $error("upper data half not zero");
  // Control read returns the mode and amp bits as stored
  ctrl_read_a: assert property (ctrlRead |=> wb_dat_o[15:0] == $past(state_reg.ctrlStore))
    else $error("control read data differs from store");
  // Route status mirrors the set B channel 1 sources
  route_read_a: assert property (
    routeRead |=> wb_dat_o[12:8] == $past(muxBNeg[0]) && wb_dat_o[4:0] == $past(muxBPos[0]))
    else $error("route status differs from routing");
  // Reserved control bits never store
  ctrl_mask_a: assert property (ctrlWrite |=> (state_reg.ctrlStore & ~CTRL_MASK) == 16'h0)
    else $error("reserved control bit stored");
  // Reserved select bits never store
  sel_mask_a: assert property (selWrite |=> (state_reg.selStore & ~SEL_MASK) == 16'h0)
    else $error("reserved select bit stored");
  // A full-width write lands masked in one cycle
  sel_full_write_a: assert property (
    (selWrite and (wb_sel_i[1:0] == 2'h3)) |=> state_reg.selStore == ($past(wb_dat_i[15:0]) & SEL_MASK))
    else $error("select write not stored");
  // A disabled high lane keeps the set B fields
  lane_keep_a: assert property (
    (selWrite and !wb_sel_i[1]) |=> state_reg.selStore[15:8] == $past(state_reg.selStore[15:8]))
    else $error("disabled lane overwritten");
  // An unmapped access answers err and changes nothing
  bad_err_a: assert property (badReq |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  bad_keep_a: assert property (badReq |=> state_reg.selStore == $past(state_reg.selStore))
    else $error("unmapped write changed select");
  // Reads answer once, like writes
  read_once_a: assert property (selRead |=> ackPulse)
    else $error("select read not answered once");

  // ==========================================================
  // Reset checks
  // ==========================================================
  // These look at the edge after release, so the default disable is overridden
  rst_store_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    $past(rst) && !rst |-> state_reg.selStore == SEL_RESET && state_reg.ctrlStore == SEL_RESET)
    else $error("reset left a field set");
  rst_idle_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    $past(rst) && !rst |-> !wb_ack_o && !wb_err_o && wb_dat_o == 32'h0)
    else $error("bus not idle after reset");

  // ==========================================================
  // Routing checks
  // ==========================================================
  // Codes 0x give the low reference on every channel
  negb_ref_a: assert property (
    !selView[POS_NB_HI] |-> muxBNeg[0] == SRC_VREFL && muxBNeg[1] == SRC_VREFL && muxBNeg[2] == SRC_VREFL)
    else $error("set B negative reference misrouted");
  // Mid code keeps pin 8 on channel 3, never lent
  negb_mid_a: assert property (selView[POS_NB_HI:POS_NB_LO] == NEG_MID_INPUTS |-> muxBNeg[2] == SRC_AN8)
    else $error("set B negative mid code misrouted");
  // High code on set A mirrors set B
  nega_high_a: assert property (
    selView[POS_NA_HI:POS_NA_LO] == NEG_HIGH_INPUTS |->
      muxANeg[0] == SRC_AN9 && muxANeg[1] == SRC_ANALOG_INPUT_10 && muxANeg[2] == SRC_ANALOG_INPUT_11)
    else $error("set A negative high code misrouted");
  // Mid code takes amp 3 when its mode bit is set
  nega_mid_amp_a: assert property (
    selView[POS_NA_HI:POS_NA_LO] == NEG_MID_INPUTS && state_reg.ctrlStore[POS_AMP3] |-> muxANeg[0] == SRC_AMP3)
    else $error("set A negative amp 3 misrouted");
  // Without amp 3 or lending the mid code uses pins 6 and 7
  negb_mid_pin_a: assert property (
    selView[POS_NB_HI:POS_NB_LO] == NEG_MID_INPUTS && !state_reg.ctrlStore[POS_AMP3] &&
      !state_reg.ctrlStore[POS_CMPEN] |-> muxBNeg[0] == SRC_AN6 && muxBNeg[1] == SRC_AN7)
    else $error("set B negative mid pins misrouted");
  // Positive bit set with amp 1 off routes pin 3
  posb_pin_a: assert property (
    selView[POS_SB] && !state_reg.ctrlStore[POS_AMP1] && !state_reg.ctrlStore[POS_CMPEN] |-> muxBPos[0] == SRC_AN3)
    else $error("set B positive pin misrouted");
  // Positive bit clear routes pins 1 and 2 on channels 2 and 3
  posb_low_a: assert property (
    !selView[POS_SB] && !state_reg.ctrlStore[POS_CMPEN] |-> muxBPos[1] == SRC_AN1 && muxBPos[2] == SRC_AN2)
    else $error("set B positive low pins misrouted");
  // Amp 3 replaces pin 6 on channel 3
  posb_amp3_a: assert property (
    selView[POS_SB] && state_reg.ctrlStore[POS_AMP3] |-> muxBPos[2] == SRC_AMP3)
    else $error("set B positive amp 3 misrouted");
  // Amp 2 replaces pin 0 on channel 1 when the bit is clear
  posb_amp2_a: assert property (
    !selView[POS_SB] && state_reg.ctrlStore[POS_AMP2] |-> muxBPos[0] == SRC_AMP2)
    else $error("set B positive amp 2 misrouted");
  // Set A bit set with amp 2 on gives amp 2 on channel 2
  posa_amp2_a: assert property (
    selView[POS_SA] && state_reg.ctrlStore[POS_AMP2] |-> muxAPos[1] == SRC_AMP2)
    else $error("set A positive amp 2 misrouted");
  // Hidden 12-bit fields route as code zero
  twelve_neg_a: assert property (
    twelveBit |-> muxBNeg[0] == SRC_VREFL && muxANeg[0] == SRC_VREFL)
    else $error("hidden negative field still routed");
  twelve_posb_a: assert property (
    twelveBit && !state_reg.ctrlStore[POS_AMP2] && !state_reg.ctrlStore[POS_CMPEN] |-> muxBPos[0] == SRC_AN0)
    else $error("hidden set B positive bit still routed");
  // Lending takes pin 7 from the mid code
  cmp_lend_neg_a: assert property (
    state_reg.ctrlStore[POS_CMPEN] && selView[POS_NB_HI:POS_NB_LO] == NEG_MID_INPUTS |-> muxBNeg[1] == SRC_VSS)
    else $error("lent pin 7 still routed");
  // Pins 9 to 11 are never lent
  cmp_keep_a: assert property (
    state_reg.ctrlStore[POS_CMPEN] && selView[POS_NB_HI:POS_NB_LO] == NEG_HIGH_INPUTS |-> muxBNeg[0] == SRC_AN9)
    else $error("high pin lost to lending");
endmodule : adcsel_top

/* File: testbench/tb_adc_aux_channel_input_select.sv */
`timescale 1ns/1ns
// ==========================================================
// Bench for the aux channel input select block
// ==========================================================
module tb_adc_aux_channel_input_select;
  import adcsel_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h3;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, wbErr;
  adcsel_src_t aPos [3], aNeg [3], bPos [3], bNeg [3];
  int err_count = 0;
  int cmp_count = 0;
  // 50 MHz system clock
  always #10 sys_clk = ~sys_clk;
  adcsel_top uut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .wb_err_o(wbErr), .muxAPos(aPos), .muxANeg(aNeg), .muxBPos(bPos), .muxBNeg(bNeg));
  // ==========================================================
  // Common helpers
  // ==========================================================
  task conclude;
    if (err_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; held until ack or err is seen at a rising edge
  task bus(input logic we, input logic [7:0] adr, input logic [15:0] dat, input logic [3:0] sel,
      output logic [31:0] data, output logic isErr);
    int n;
    @(posedge sys_clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= adr; wbSel <= sel; wbDatI <= {16'h0, dat};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 20);
    // A missing answer ends the run as a failure
    if (n >= 20) begin
      err_count++;
      conclude();
    end
    data = wbDatO;
    isErr = wbErr;
    // Drop at once, otherwise the slave takes the request again
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task wr(input logic [7:0] adr, input logic [15:0] dat);
    logic [31:0] d;
    logic e;
    bus(1'b1, adr, dat, 4'h3, d, e);
  endtask : wr
  task rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    bus(1'b0, adr, 16'h0, 4'h3, d, e);
    check(d, exp);
  endtask : rdchk
  task chk3(input adcsel_src_t s [3], input adcsel_src_t e0, input adcsel_src_t e1, input adcsel_src_t e2);
    check(32'(s[0]), 32'(e0));
    check(32'(s[1]), 32'(e1));
    check(32'(s[2]), 32'(e2));
  endtask : chk3
  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_reset;
    rdchk(SEL_ADDR, 32'h0);
    chk3(aPos, SRC_AN0, SRC_AN1, SRC_AN2);
    chk3(bNeg, SRC_VREFL, SRC_VREFL, SRC_VREFL);
  endtask : t_reset
  task t_mask;
    logic [31:0] d;
    logic e;
    wr(SEL_ADDR, 16'hffff);
    rdchk(SEL_ADDR, 32'h0707);
    // Only the low lane is enabled, so the high byte survives
    bus(1'b1, SEL_ADDR, 16'h0000, 4'h1, d, e);
    rdchk(SEL_ADDR, 32'h0700);
  endtask : t_mask
  task t_neg;
    adcsel_src_t e [3];
    for (int c = 0; c < 4; c++) begin
      wr(SEL_ADDR, {5'h0, 2'(c), 1'b0, 5'h0, 2'(c), 1'b0});
      // Amp 3 is off, so the mid code uses the pin
      e[0] = (c == 3) ? SRC_AN9 : (c == 2) ? SRC_AN6 : SRC_VREFL;
      e[1] = (c == 3) ? SRC_ANALOG_INPUT_10 : (c == 2) ? SRC_AN7 : SRC_VREFL;
      e[2] = (c == 3) ? SRC_ANALOG_INPUT_11 : (c == 2) ? SRC_AN8 : SRC_VREFL;
      chk3(aNeg, e[0], e[1], e[2]);
      chk3(bNeg, e[0], e[1], e[2]);
    end
    rdchk(ROUTE_ADDR, {19'h0, 5'(SRC_AN9), 3'h0, 5'(SRC_AN0)});
  endtask : t_neg
  task t_pos;
    wr(CTRL_ADDR, 16'h0000);
    wr(SEL_ADDR, 16'h0101);
    chk3(bPos, SRC_AN3, SRC_AN0, SRC_AN6);
    chk3(aPos, SRC_AN3, SRC_AN0, SRC_AN6);
    wr(CTRL_ADDR, 16'h000e);
    chk3(bPos, SRC_AMP1, SRC_AMP2, SRC_AMP3);
    wr(SEL_ADDR, 16'h0000);
    chk3(aPos, SRC_AMP2, SRC_AN1, SRC_AN2);
    chk3(bPos, SRC_AMP2, SRC_AN1, SRC_AN2);
  endtask : t_pos
  task t_twelve;
    wr(SEL_ADDR, 16'h0707);
    wr(CTRL_ADDR, 16'h0001);
    rdchk(SEL_ADDR, 32'h0001);
    wr(CTRL_ADDR, 16'hffff);
    rdchk(CTRL_ADDR, 32'h001f);
    // Leaving 12-bit mode brings the stored fields back
    wr(CTRL_ADDR, 16'h0000);
    rdchk(SEL_ADDR, 32'h0707);
  endtask : t_twelve
  task t_lend;
    wr(SEL_ADDR, 16'h0006);
    wr(CTRL_ADDR, 16'h0010);
    chk3(aPos, SRC_VSS, SRC_VSS, SRC_VSS);
    chk3(aNeg, SRC_AN9, SRC_ANALOG_INPUT_10, SRC_ANALOG_INPUT_11);
    wr(CTRL_ADDR, 16'h0000);
  endtask : t_lend
  task t_unmapped;
    logic [31:0] d;
    logic e;
    bus(1'b1, 8'h0c, 16'hffff, 4'h3, d, e);
    check({31'h0, e}, 32'h1);
    rdchk(SEL_ADDR, 32'h0006);
  endtask : t_unmapped
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_mask();
    t_neg();
    t_pos();
    t_twelve();
    t_lend();
    t_unmapped();
    conclude();
  end
endmodule : tb_adc_aux_channel_input_select
